// file: src/ricc_consts.svh
`ifndef RICC_CONSTS_SVH
`define RICC_CONSTS_SVH

// ==========================================================
// Register map (word index, byte address is four times it)
`define RICC_CFG_INDEX      8'h2B
`define RICC_CFG_ADDR       8'hAC
`define RICC_STAT_INDEX     8'h30
`define RICC_STAT_ADDR      8'hC0

// ==========================================================
// Configuration fields and reset value
`define RICC_CFG_RESET      8'h01
`define RICC_PREDIV_BIT     7
`define RICC_FIXED8K_BIT    6
`define RICC_PROFILE_HI     5
`define RICC_PROFILE_LO     4
`define RICC_FREQ_HI        3
`define RICC_FREQ_LO        0

// ==========================================================
// Frequency codes
`define RICC_FREQ_8K        4'h0
`define RICC_FREQ_T1E1      4'h1
`define RICC_FREQ_UNUSED    4'hF

// ==========================================================
// Status fields
`define RICC_STAT_PATH_HI   1
`define RICC_STAT_PATH_LO   0
`define RICC_STAT_SONET_BIT 2
`define RICC_STAT_RSVD_BIT  3
`define RICC_PATH_DIRECT    2'h0
`define RICC_PATH_FIXED8K   2'h1
`define RICC_PATH_PREDIV    2'h2

// ==========================================================
// Decoded output reset values
`define RICC_PREDIV_RESET   1'b0
`define RICC_FIXED8K_RESET  1'b0
`define RICC_PROFILE_RESET  2'h0
`define RICC_FREQ_RESET     4'h1
`define RICC_RATE_RESET     1'b0

`endif

// file: src/ricc_pkg.sv
package ricc_pkg;

	typedef enum logic [1:0] {
		RICC_BUS_IDLE = 2'b01,
		RICC_BUS_ACK  = 2'b10
	} ricc_bus_state_type;

	typedef logic [7:0] ricc_cfg_type;

endpackage

// file: src/ricc_top.sv
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "ricc_consts.svh"
// Behaviour
// - The channel has an 8-bit read-write configuration register that resets to 0x01.
// - Bit 7 at 1 routes the input through the programmable pre-divider to the DPLL and monitor, at 0 directly.
// - Bit 6 at 1 routes the input to the DPLL through the fixed divide-to-8 kHz divider, at 0 directly.
// - Bit 6 is ignored while bit 7 is 1, so only the programmable divider path applies.
// - This channel's leaky-bucket monitor uses its own profile choice, independent of other channels.
// - Bits 5 to 4 pick leaky-bucket profile 0 to 3 and reset to 00.
// - Bits 3 to 0 set the expected input frequency, reset 0001, with 1111 unused.
// - Code 0001 means 1544 kHz or 2048 kHz depending on the SONET/SDH rate select.
module ricc_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        sonet_sdh_rate_select_i,
	output logic             prediv_path_o,
	output logic             fixed_8k_path_o,
	output logic      [1:0]  activity_profile_select_o,
	output logic      [3:0]  freq_code_o,
	output logic             rate_1544_o,
	output logic             rate_2048_o
);
	import ricc_pkg::*;

	// ==========================================================
	// Bus decode
	ricc_bus_state_type state_q;
	ricc_bus_state_type state_d;
	ricc_cfg_type       cfg_q;
	ricc_cfg_type       cfg_d;
	logic [31:0]        rdata_d;
	logic [7:0]         status_w;
	logic [1:0]         path_w;
	logic               req_w;
	logic               hit_cfg_w;
	logic               hit_stat_w;
	logic               cfg_wr_w;
	logic               fixed_eff_w;
	logic               code_t1e1_w;

	assign req_w       = wb_cyc_i && wb_stb_i && (state_q == RICC_BUS_IDLE);
	assign hit_cfg_w   = (wb_adr_i == `RICC_CFG_ADDR);
	assign hit_stat_w  = (wb_adr_i == `RICC_STAT_ADDR);
	assign cfg_wr_w    = req_w && wb_we_i && hit_cfg_w && wb_sel_i[0];

	// Any write value is kept, reserved frequency codes included
	assign cfg_d       = cfg_wr_w ? ricc_cfg_type'(wb_dat_i[7:0]) : cfg_q;

	// A request held through its ack cycle is taken again one cycle later
	always_comb begin
		case (state_q)
			RICC_BUS_IDLE: begin
				state_d = req_w ? RICC_BUS_ACK : RICC_BUS_IDLE;
			end
			default: begin
				state_d = RICC_BUS_IDLE;
			end
		endcase
	end

	// ==========================================================
	// Path and rate decode
	assign fixed_eff_w = cfg_q[`RICC_FIXED8K_BIT] && !cfg_q[`RICC_PREDIV_BIT];
	assign path_w      = cfg_q[`RICC_PREDIV_BIT] ? `RICC_PATH_PREDIV :
	                     (fixed_eff_w ? `RICC_PATH_FIXED8K : `RICC_PATH_DIRECT);
	assign code_t1e1_w = (cfg_q[`RICC_FREQ_HI:`RICC_FREQ_LO] == `RICC_FREQ_T1E1);
	assign status_w    = {4'h0, (cfg_q[`RICC_FREQ_HI:`RICC_FREQ_LO] == `RICC_FREQ_UNUSED),
	                      sonet_sdh_rate_select_i, path_w};

	// Unmapped addresses read zero and ignore writes
	always_comb begin
		if (hit_cfg_w) begin
			rdata_d = {24'h00_0000, cfg_q};
		end else if (hit_stat_w) begin
			rdata_d = {24'h00_0000, status_w};
		end else begin
			rdata_d = 32'h0000_0000;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q  <= RICC_BUS_IDLE;
			cfg_q    <= `RICC_CFG_RESET;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			state_q  <= state_d;
			cfg_q    <= cfg_d;
			wb_ack_o <= req_w;
			wb_dat_o <= req_w ? rdata_d : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prediv_path_o             <= `RICC_PREDIV_RESET;
			fixed_8k_path_o           <= `RICC_FIXED8K_RESET;
			activity_profile_select_o <= `RICC_PROFILE_RESET;
			freq_code_o               <= `RICC_FREQ_RESET;
			rate_1544_o               <= `RICC_RATE_RESET;
			rate_2048_o               <= `RICC_RATE_RESET;
		end else begin
			prediv_path_o             <= cfg_q[`RICC_PREDIV_BIT];
			fixed_8k_path_o           <= fixed_eff_w;
			activity_profile_select_o <= cfg_q[`RICC_PROFILE_HI:`RICC_PROFILE_LO];
			freq_code_o               <= cfg_q[`RICC_FREQ_HI:`RICC_FREQ_LO];
			rate_1544_o               <= code_t1e1_w && sonet_sdh_rate_select_i;
			rate_2048_o               <= code_t1e1_w && !sonet_sdh_rate_select_i;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_cfg_write;
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && hit_cfg_w && wb_sel_i[0];
	endsequence

	sequence s_cfg_read;
		wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && hit_cfg_w;
	endsequence

	sequence s_cfg_masked;
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && hit_cfg_w && !wb_sel_i[0];
	endsequence

	sequence s_other_write;
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !hit_cfg_w;
	endsequence

	sequence s_stat_read;
		wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && hit_stat_w;
	endsequence

	sequence s_other_read;
		wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && !hit_cfg_w && !hit_stat_w;
	endsequence

	sequence s_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	a_reset_value: assert property (disable iff (1'b0) rst_i |=> cfg_q == `RICC_CFG_RESET)
		else $error("config register did not reset to 0x01");
	a_write_store: assert property (s_cfg_write |=> wb_ack_o && cfg_q == $past(wb_dat_i[7:0]))
		else $error("config write not stored with its ack");
	a_read_back: assert property (s_cfg_read |=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(cfg_q)})
		else $error("config read returned wrong data");
	a_prediv_path: assert property (##1 prediv_path_o == $past(cfg_q[`RICC_PREDIV_BIT]))
		else $error("pre-divider path does not follow bit 7");
	a_fixed_path: assert property (cfg_q[`RICC_FIXED8K_BIT] && !cfg_q[`RICC_PREDIV_BIT] |=> fixed_8k_path_o)
		else $error("fixed 8 kHz path not taken");
	a_fixed_ignored: assert property (prediv_path_o |-> !fixed_8k_path_o)
		else $error("fixed divider active with pre-divider selected");
	a_profile_sel: assert property (##1 activity_profile_select_o ==
		$past(cfg_q[`RICC_PROFILE_HI:`RICC_PROFILE_LO]))
		else $error("profile select does not follow bits 5 to 4");
	a_freq_code: assert property (##1 freq_code_o == $past(cfg_q[`RICC_FREQ_HI:`RICC_FREQ_LO]))
		else $error("frequency code does not follow bits 3 to 0");
	a_rate_pick: assert property (rate_1544_o |-> !rate_2048_o && $past(sonet_sdh_rate_select_i) &&
		$past(cfg_q[`RICC_FREQ_HI:`RICC_FREQ_LO]) == `RICC_FREQ_T1E1)
		else $error("1544 kHz chosen without code 0001 and rate select");
	a_rate_2048: assert property (rate_2048_o |-> !rate_1544_o && !$past(sonet_sdh_rate_select_i) &&
		$past(cfg_q[`RICC_FREQ_HI:`RICC_FREQ_LO]) == `RICC_FREQ_T1E1)
		else $error("2048 kHz chosen without code 0001 and SDH select");
	a_rate_other: assert property (cfg_q[`RICC_FREQ_HI:`RICC_FREQ_LO] != `RICC_FREQ_T1E1 |=>
		!rate_1544_o && !rate_2048_o)
		else $error("rate output raised for a code other than 0001");
	a_rsvd_store: assert property ((s_cfg_write and
		(wb_dat_i[`RICC_FREQ_HI:`RICC_FREQ_LO] == `RICC_FREQ_UNUSED)) |=> ##1 freq_code_o == `RICC_FREQ_UNUSED)
		else $error("reserved frequency code not kept");

	// ==========================================================
	// Bus handshake checks
	a_write_ack: assert property (s_cfg_write |=> s_ack_pulse)
		else $error("config write not acked for exactly one cycle");
	a_read_ack: assert property (s_cfg_read |=> s_ack_pulse)
		else $error("config read not acked for exactly one cycle");
	a_ack_only_req: assert property (!(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> !wb_ack_o)
		else $error("ack given without a request");
	a_ack_state: assert property (wb_ack_o == (state_q == RICC_BUS_ACK))
		else $error("ack and bus state disagree");
	a_state_onehot: assert property ($onehot(state_q))
		else $error("bus state is not one-hot");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data not zero outside ack");
	a_ack_reset: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && wb_dat_o == 32'h0000_0000)
		else $error("bus outputs not cleared by reset");
	a_other_zero: assert property (s_other_read |=> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read did not return zero");

	// ==========================================================
	// Register content checks
	a_cfg_hold: assert property (!cfg_wr_w |=> cfg_q == $past(cfg_q))
		else $error("config register changed without a write");
	a_masked_keep: assert property (s_cfg_masked |=> cfg_q == $past(cfg_q))
		else $error("config write with byte lane 0 off was stored");
	a_other_keep: assert property (s_other_write |=> cfg_q == $past(cfg_q))
		else $error("write to another address changed the config register");
	a_stat_path: assert property (s_stat_read |=> wb_dat_o[`RICC_STAT_PATH_HI:`RICC_STAT_PATH_LO] ==
		($past(cfg_q[`RICC_PREDIV_BIT]) ? `RICC_PATH_PREDIV :
		($past(cfg_q[`RICC_FIXED8K_BIT]) ? `RICC_PATH_FIXED8K : `RICC_PATH_DIRECT)))
		else $error("status path field wrong");
	a_stat_flags: assert property (s_stat_read |=>
		wb_dat_o[`RICC_STAT_SONET_BIT] == $past(sonet_sdh_rate_select_i) &&
		wb_dat_o[`RICC_STAT_RSVD_BIT] == ($past(cfg_q[`RICC_FREQ_HI:`RICC_FREQ_LO]) == `RICC_FREQ_UNUSED))
		else $error("status flags wrong");
	a_prediv_wins: assert property (cfg_q[`RICC_PREDIV_BIT] |=> prediv_path_o && !fixed_8k_path_o)
		else $error("pre-divider path not taken alone");
	a_fixed_clear: assert property (!cfg_q[`RICC_FIXED8K_BIT] |=> !fixed_8k_path_o)
		else $error("fixed divider active with bit 6 clear");
	a_outs_reset: assert property (disable iff (1'b0) rst_i |=>
		prediv_path_o == `RICC_PREDIV_RESET && fixed_8k_path_o == `RICC_FIXED8K_RESET &&
		activity_profile_select_o == `RICC_PROFILE_RESET && freq_code_o == `RICC_FREQ_RESET)
		else $error("decoded outputs not at reset values");

endmodule

// file: verification/tb_ricc_top.sv
`timescale 1ns/1ps
`include "ricc_consts.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_ricc_top;
	import ricc_pkg::*;
	logic         clk_i = 0;
	logic         rst_i = 1;
	logic         cyc = 0;
	logic         stb = 0;
	logic         we = 0;
	logic         rsel = 0;
	logic [7:0]   adr = 0;
	logic [3:0]   sel = 0;
	logic [31:0]  dat = 0;
	logic [31:0]  q;
	logic [31:0]  rdat;
	logic         ack;
	logic         p_o, f_o, r15, r20;
	logic [1:0]   prof;
	logic [3:0]   fc;
	logic [1:0]   path;
	ricc_cfg_type v;
	int           n_fail = 0;
	int           total_checks = 0;

	always #2.5 clk_i = ~clk_i;

	ricc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .sonet_sdh_rate_select_i(rsel),
		.prediv_path_o(p_o), .fixed_8k_path_o(f_o), .activity_profile_select_o(prof), .freq_code_o(fc),
		.rate_1544_o(r15), .rate_2048_o(r20));

	// ==========================================================
	// Bus tasks
	task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		`CHK("ack latency", 2, n)
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 4'hF, 32'h0000_0000);
		`CHK("read data", e, q)
	endtask

	// Decoded outputs follow the stored value one clock later
	task automatic outs(input ricc_cfg_type c, input logic s);
		logic [9:0] e;
		@(posedge clk_i);
		#1;
		e = {c[7], c[6] & ~c[7], c[5:4], c[3:0], c[3:0] == `RICC_FREQ_T1E1 && s, c[3:0] == `RICC_FREQ_T1E1 && !s};
		`CHK("outputs", e, {p_o, f_o, prof, fc, r15, r20})
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		repeat (4000) @(posedge clk_i);
		n_fail++;
		complete_run();
	end

	// ==========================================================
	// Tests
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		outs(8'h01, 1'b0);
		rd(`RICC_CFG_ADDR, 32'h0000_0001);
		$display("test reset done");
		for (int s = 0; s < 2; s++) begin
			for (int i = 0; i < 16; i++) begin
				v = {i[3], i[2], i[1:0], i[3:0]};
				rsel <= s[0];
				xfer(1'b1, `RICC_CFG_ADDR, 4'h1, {24'h0, v});
				outs(v, s[0]);
				rd(`RICC_CFG_ADDR, {24'h0, v});
				path = v[7] ? `RICC_PATH_PREDIV : (v[6] ? `RICC_PATH_FIXED8K : `RICC_PATH_DIRECT);
				rd(`RICC_STAT_ADDR, {28'h0, v[3:0] == 4'hF, s[0], path});
			end
		end
		$display("test field sweep done");
		xfer(1'b1, `RICC_CFG_ADDR, 4'hE, 32'h0000_0055);
		rd(`RICC_CFG_ADDR, {24'h0, v});
		xfer(1'b1, 8'h04, 4'hF, 32'h0000_0000);
		rd(8'h04, 32'h0000_0000);
		xfer(1'b1, `RICC_STAT_ADDR, 4'hF, 32'h0000_0000);
		rd(`RICC_CFG_ADDR, {24'h0, v});
		$display("test refusals done");
		v = 8'h80;
		xfer(1'b1, `RICC_CFG_ADDR, 4'h1, {24'h0, v});
		outs(v, rsel);
		$display("test prediv with 8 kHz code done");
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		outs(`RICC_CFG_RESET, rsel);
		rd(`RICC_CFG_ADDR, {24'h0, `RICC_CFG_RESET});
		$display("test mid-run reset done");
		complete_run();
	end
endmodule
